// file: pcr_regs.sv
// Configuration register bank of a dual-buck regulator unit.
// Assumes a host drives the serial link as master; no other bus.
// Assumes the pins and the select are asynchronous to sys_clk,
// and that the select stays high a few clocks between frames.
// Assumes the regulators read the control pins as plain levels.
//
// Contract
// - Second buck code, seven bits, resets 0x64.
// - First buck code, six bits, resets 0x0E.
// - Control bit 3 forces first buck PWM.
// - Control bit 2 forces second buck PWM.
// - Control bit 0 enables first buck, default on.
// - Monitor bits 6..1 select VIN trip level.
// - Trip code resets to 0x19.
// - Monitor bit 7 doubles comparator hysteresis.
// - Hysteresis double bit resets clear.
// - Read frame returns addressed register's eight bits.
// - Status shows regulator good and comparator high.
`timescale 1ns/1ps
`default_nettype none

module pcr_regs (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       spi_clk,
    input  wire logic       spi_cs_n,
    input  wire logic       spi_sdi,
    output logic            spi_sdo,
    input  wire logic       ldo_good,
    input  wire logic       buck_two_good,
    input  wire logic       buck_one_good,
    input  wire logic       vin_cmp_high,
    output logic [6:0]      buck_two_code,
    output logic [5:0]      buck_one_code,
    output logic            first_buck_fixed_pwm,
    output logic            second_buck_fixed_pwm,
    output logic            first_buck_on,
    output logic [5:0]      vin_trip_code,
    output logic            vin_hyst_double,
    output logic            vin_monitor_on,
    output logic [4:0]      event_mask
);

    // --------------------------------------------------------------
    // Storage
    // --------------------------------------------------------------
    // Buck codes, control and monitor
    logic [6:0]  buck_two_q;
    logic [5:0]  buck_one_q;
    logic [3:0]  reg_ctl_q;
    logic [7:0]  vin_mon_q;
    // Mask, status snapshot and select history
    logic [4:0]  evt_mask_q;
    logic [4:0]  evt_stat_q;
    logic        cs_prev_q;

    // Next values
    logic [6:0]  buck_two_d;
    logic [5:0]  buck_one_d;
    logic [3:0]  reg_ctl_d;
    logic [7:0]  vin_mon_d;
    logic [4:0]  evt_mask_d;
    logic [4:0]  evt_stat_d;

    // Link side and synchronised pins
    logic [3:0]  link_cnt;
    logic [14:0] link_word;
    logic [4:0]  pin_sync;

    // Select and frame fields
    wire         cs_n_s;
    wire         frame_end;
    wire  [1:0]  frame_cmd;
    wire  [4:0]  frame_addr;
    wire  [7:0]  frame_data;
    wire         frame_wr;

    // Write strobes
    wire         wr_buck_two;
    wire         wr_buck_one;
    wire         wr_reg_ctl;
    wire         wr_vin_mon;
    wire         wr_evt_mask;

    // Live status
    wire  [4:0]  stat_live;

    // Read images for the link
    wire  [7:0]  rd_buck_two;
    wire  [7:0]  rd_buck_one;
    wire  [7:0]  rd_reg_ctl;
    wire  [7:0]  rd_vin_mon;
    wire  [7:0]  rd_evt_mask;
    wire  [7:0]  rd_evt_stat;

    // --------------------------------------------------------------
    // Clock crossing
    // --------------------------------------------------------------
    // Writes cross on the select alone: the link word stands still
    // once the select rises, and is taken three edges later.
    // Reads cross the other way as held images: the bank moves only
    // after a frame, so nothing the link samples moves mid-frame.
    // No multi-bit word crosses except behind the select.
    // A gap shorter than three system clocks can lose a write.
    // The status snapshot is frozen for the same reason.

    // --------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------
    // Select on top, then the good and comparator levels
    pcr_sync u_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in ({spi_cs_n, ldo_good, buck_two_good,
                    buck_one_good, vin_cmp_high}),
        .sync_out (pin_sync)
    );

    assign cs_n_s = pin_sync[4];

    // Live status bits in the same positions as the mask
    assign stat_live = {pin_sync[3], pin_sync[2], pin_sync[1],
                        1'b0, pin_sync[0]};

    // --------------------------------------------------------------
    // Serial link on its own clock
    // --------------------------------------------------------------
    // Hands back a word that stays put while the select is high
    pcr_spi_link u_link (
        .spi_clk     (spi_clk),
        .spi_cs_n    (spi_cs_n),
        .spi_sdi     (spi_sdi),
        .rd_buck_two (rd_buck_two),
        .rd_buck_one (rd_buck_one),
        .rd_reg_ctl  (rd_reg_ctl),
        .rd_vin_mon  (rd_vin_mon),
        .rd_evt_mask (rd_evt_mask),
        .rd_evt_stat (rd_evt_stat),
        .spi_sdo     (spi_sdo),
        .bit_cnt     (link_cnt),
        .frame_word  (link_word)
    );

    // --------------------------------------------------------------
    // Read images, unused bits read as zero
    // --------------------------------------------------------------
    // The link samples these at its seventh rise, mid-frame
    // Control bit 1 is kept and read back but drives no pin
    assign rd_buck_two = {1'b0, buck_two_q};
    assign rd_buck_one = {2'b00, buck_one_q};
    assign rd_reg_ctl  = {4'h0, reg_ctl_q};
    assign rd_vin_mon  = vin_mon_q;
    assign rd_evt_mask = {3'b000, evt_mask_q};
    assign rd_evt_stat = {3'b000, evt_stat_q};

    // --------------------------------------------------------------
    // Frame completion and write decode
    // --------------------------------------------------------------
    // Edges one and two after the select rises fill the synchroniser;
    // edge three sees the frame end and the write lands.
    // Link fields are still once the select has risen and synced
    assign frame_end   = cs_n_s && !cs_prev_q;
    assign frame_cmd   = link_word[pcr_pkg::CMD_MSB:pcr_pkg::CMD_LSB];
    assign frame_addr  = link_word[pcr_pkg::ADDR_MSB:pcr_pkg::ADDR_LSB];
    assign frame_data  = link_word[7:0];
    // Short frames and bad commands never raise a strobe
    assign frame_wr    = frame_end
                      && (link_cnt == pcr_pkg::FRAME_BITS)
                      && (frame_cmd == pcr_pkg::CMD_WRITE);

    // Reserved slots and the status address have no write strobe
    assign wr_buck_two = frame_wr
                      && pcr_pkg::addr_hit(frame_addr, pcr_pkg::ADDR_BUCK_TWO);
    assign wr_buck_one = frame_wr
                      && pcr_pkg::addr_hit(frame_addr, pcr_pkg::ADDR_BUCK_ONE);
    assign wr_reg_ctl  = frame_wr
                      && pcr_pkg::addr_hit(frame_addr, pcr_pkg::ADDR_REG_CTL);
    assign wr_vin_mon  = frame_wr
                      && pcr_pkg::addr_hit(frame_addr, pcr_pkg::ADDR_VIN_MON);
    assign wr_evt_mask = frame_wr
                      && pcr_pkg::addr_hit(frame_addr, pcr_pkg::ADDR_EVT_MASK);

    // --------------------------------------------------------------
    // Next-value selection
    // --------------------------------------------------------------
    // Buck output codes
    assign buck_two_d = wr_buck_two ? frame_data[6:0] : buck_two_q;
    assign buck_one_d = wr_buck_one ? frame_data[5:0] : buck_one_q;

    // Buck control: PWM forcing, reserved bit 1, first buck enable
    assign reg_ctl_d  = wr_reg_ctl ? frame_data[3:0] : reg_ctl_q;

    // VIN monitor: hysteresis, trip code, comparator enable
    assign vin_mon_d  = wr_vin_mon ? frame_data : vin_mon_q;

    // Event mask, bit 1 kept as plain storage
    assign evt_mask_d = wr_evt_mask ? frame_data[4:0] : evt_mask_q;

    // Status snapshot only moves between frames
    // so that a read shifts out one coherent byte
    assign evt_stat_d = cs_n_s ? stat_live : evt_stat_q;

    // --------------------------------------------------------------
    // Register update
    // --------------------------------------------------------------
    // Bank registers reset synchronously; the link has no reset
    // and restarts on every rise of the select instead.
    // Second buck code
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            buck_two_q <= pcr_pkg::RST_BUCK_TWO;
        end else begin
            buck_two_q <= buck_two_d;
        end
    end

    // First buck code
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            buck_one_q <= pcr_pkg::RST_BUCK_ONE;
        end else begin
            buck_one_q <= buck_one_d;
        end
    end

    // Buck control
    // Bits above 3 are absent and read back as zero
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_ctl_q <= pcr_pkg::RST_REG_CTL;
        end else begin
            reg_ctl_q <= reg_ctl_d;
        end
    end

    // VIN monitor control
    // Reset image: hysteresis clear, trip code set, comparator on
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            vin_mon_q <= {pcr_pkg::RST_HYST,
                          pcr_pkg::RST_TRIP,
                          pcr_pkg::RST_MON_ON};
        end else begin
            vin_mon_q <= vin_mon_d;
        end
    end

    // Event mask
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            evt_mask_q <= pcr_pkg::RST_EVT_MASK;
        end else begin
            evt_mask_q <= evt_mask_d;
        end
    end

    // Status snapshot
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            evt_stat_q <= 5'h00;
        end else begin
            evt_stat_q <= evt_stat_d;
        end
    end

    // Previous synced select, for the frame-end edge
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cs_prev_q <= 1'b1;
        end else begin
            cs_prev_q <= cs_n_s;
        end
    end

    // --------------------------------------------------------------
    // Control outputs, straight from the registers
    // --------------------------------------------------------------
    // Each pin is a register bit with nothing after it
    assign buck_two_code         = buck_two_q;
    assign buck_one_code         = buck_one_q;

    // Buck mode and enable bits
    assign first_buck_fixed_pwm  = reg_ctl_q[pcr_pkg::CTL_B1_FPWM];
    assign second_buck_fixed_pwm = reg_ctl_q[pcr_pkg::CTL_B2_FPWM];
    assign first_buck_on         = reg_ctl_q[pcr_pkg::CTL_B1_ON];

    // VIN monitor fields
    assign vin_trip_code         =
        vin_mon_q[pcr_pkg::MON_TRIP_MSB:pcr_pkg::MON_TRIP_LSB];
    assign vin_hyst_double       = vin_mon_q[pcr_pkg::MON_HYST];
    assign vin_monitor_on        = vin_mon_q[pcr_pkg::MON_ON];

    // Mask is only stored; no interrupt logic here
    assign event_mask            = evt_mask_q;

endmodule

`default_nettype wire

// file: pcr_pkg.sv
// Constants for the regulator configuration register bank.
// Assumes a 4-wire serial link framed by an active-low select.
`default_nettype none

package pcr_pkg;

    // ----------------------------------------------------------------
    // Serial frame layout
    // ----------------------------------------------------------------
    localparam logic [1:0] CMD_WRITE   = 2'h2;     // One then zero
    localparam logic [1:0] CMD_READ    = 2'h3;     // One then one
    localparam logic [3:0] HEAD_BITS   = 4'h7;     // Command plus address
    localparam logic [3:0] FRAME_BITS  = 4'hF;     // Command, address, data
    localparam int         CMD_MSB     = 14;
    localparam int         CMD_LSB     = 13;
    localparam int         ADDR_MSB    = 12;
    localparam int         ADDR_LSB    = 8;

    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [4:0] ADDR_BUCK_TWO  = 5'h00;
    localparam logic [4:0] ADDR_RSVD_A    = 5'h07;
    localparam logic [4:0] ADDR_BUCK_ONE  = 5'h08;
    localparam logic [4:0] ADDR_RSVD_B    = 5'h09;
    localparam logic [4:0] ADDR_REG_CTL   = 5'h0A;
    localparam logic [4:0] ADDR_VIN_MON   = 5'h0B;
    localparam logic [4:0] ADDR_EVT_MASK  = 5'h0C;
    localparam logic [4:0] ADDR_EVT_STAT  = 5'h0D;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [6:0] RST_BUCK_TWO   = 7'h64;
    localparam logic [5:0] RST_BUCK_ONE   = 6'h0E;
    localparam logic [3:0] RST_REG_CTL    = 4'h1;  // Bit 0 on, rest clear
    localparam logic       RST_HYST       = 1'h0;
    localparam logic [5:0] RST_TRIP       = 6'h19;
    localparam logic       RST_MON_ON     = 1'h1;
    localparam logic [4:0] RST_EVT_MASK   = 5'h01;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTL_B1_FPWM  = 3;
    localparam int CTL_B2_FPWM  = 2;
    localparam int CTL_B1_ON    = 0;
    localparam int MON_HYST     = 7;
    localparam int MON_TRIP_MSB = 6;
    localparam int MON_TRIP_LSB = 1;
    localparam int MON_ON       = 0;
    localparam int EVT_LDO      = 4;
    localparam int EVT_B2       = 3;
    localparam int EVT_B1       = 2;
    localparam int EVT_CMP      = 0;

    // Address match on the frame's address field
    function automatic logic addr_hit(input logic [4:0] a, input logic [4:0] r);
        addr_hit = (a == r);
    endfunction

endpackage

`default_nettype wire

// file: pcr_sync.sv
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes sys_clk and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module pcr_sync (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic [4:0] async_in,
    output logic      [4:0] sync_out
);

    // Select idles high, so its stages reset to one
    localparam logic [4:0] RST_LEVEL = 5'h10;

    logic [4:0] meta_q;
    logic [4:0] sync_q;

    // First stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_q <= RST_LEVEL;
            sync_q <= RST_LEVEL;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

`default_nettype wire

// file: pcr_spi_link.sv
// Serial link shifter on the link's own clock.
// Assumes read bytes are held still while the select is low.
`timescale 1ns/1ps
`default_nettype none

module pcr_spi_link (
    input  wire logic        spi_clk,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_sdi,
    input  wire logic [7:0]  rd_buck_two,
    input  wire logic [7:0]  rd_buck_one,
    input  wire logic [7:0]  rd_reg_ctl,
    input  wire logic [7:0]  rd_vin_mon,
    input  wire logic [7:0]  rd_evt_mask,
    input  wire logic [7:0]  rd_evt_stat,
    output logic             spi_sdo,
    output logic [3:0]       bit_cnt,
    output logic [14:0]      frame_word
);

    localparam logic [3:0] HEAD_BITS = pcr_pkg::HEAD_BITS;

    logic        first_q;
    logic [3:0]  cnt_q;
    logic [14:0] sr_q;
    logic [7:0]  tx_q;
    logic        sdo_q;
    wire  [1:0]  head_cmd;
    wire  [4:0]  head_addr;
    wire         head_done;
    wire  [7:0]  rd_byte;

    // --------------------------------------------------------------
    // Read selection at the seventh edge
    // --------------------------------------------------------------
    assign head_cmd  = sr_q[5:4];
    assign head_addr = {sr_q[3:0], spi_sdi};
    assign head_done = !first_q && (cnt_q == HEAD_BITS - 4'h1);
    assign rd_byte   =
        pcr_pkg::addr_hit(head_addr, pcr_pkg::ADDR_BUCK_TWO) ? rd_buck_two :
        pcr_pkg::addr_hit(head_addr, pcr_pkg::ADDR_BUCK_ONE) ? rd_buck_one :
        pcr_pkg::addr_hit(head_addr, pcr_pkg::ADDR_REG_CTL)  ? rd_reg_ctl  :
        pcr_pkg::addr_hit(head_addr, pcr_pkg::ADDR_VIN_MON)  ? rd_vin_mon  :
        pcr_pkg::addr_hit(head_addr, pcr_pkg::ADDR_EVT_MASK) ? rd_evt_mask :
        pcr_pkg::addr_hit(head_addr, pcr_pkg::ADDR_EVT_STAT) ? rd_evt_stat :
        8'h00;

    // Marks the next edge as the first of a frame
    always_ff @(posedge spi_clk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    // Bit count and shift-in, frozen after the last bit
    always_ff @(posedge spi_clk) begin
        if (first_q) begin
            cnt_q <= 4'h1;
            sr_q  <= {14'h0, spi_sdi};
        end else if (cnt_q != pcr_pkg::FRAME_BITS) begin
            cnt_q <= 4'(cnt_q + 4'h1);
            sr_q  <= {sr_q[13:0], spi_sdi};
        end
    end

    // Read data loads after the address, else shifts out zeros
    always_ff @(posedge spi_clk) begin
        if (head_done && head_cmd == pcr_pkg::CMD_READ) begin
            tx_q <= rd_byte;
        end else if (first_q) begin
            tx_q <= 8'h00;
        end else begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // Output changes on the falling edge, low outside frames
    always_ff @(negedge spi_clk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            sdo_q <= 1'b0;
        end else begin
            sdo_q <= tx_q[7];
        end
    end

    assign spi_sdo    = sdo_q;
    assign bit_cnt    = cnt_q;
    assign frame_word = sr_q;

endmodule

`default_nettype wire

// file: pcr_regs_sva.sv
// Port checker for the regulator configuration register bank.
// Assumes it is bound to pcr_regs; link frames are framed by spi_cs_n.
`timescale 1ns/1ps
`default_nettype none

module pcr_regs_chk (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       spi_clk,
    input wire logic       spi_cs_n,
    input wire logic       spi_sdi,
    input wire logic       spi_sdo,
    input wire logic       ldo_good,
    input wire logic       buck_two_good,
    input wire logic       buck_one_good,
    input wire logic       vin_cmp_high,
    input wire logic [6:0] buck_two_code,
    input wire logic [5:0] buck_one_code,
    input wire logic       first_buck_fixed_pwm,
    input wire logic       second_buck_fixed_pwm,
    input wire logic       first_buck_on,
    input wire logic [5:0] vin_trip_code,
    input wire logic       vin_hyst_double,
    input wire logic       vin_monitor_on,
    input wire logic [4:0] event_mask
);
    // ------------------------------------------------------------
    // Frame tracking on the link clock
    // ------------------------------------------------------------
    logic [4:0] cnt_q;
    logic [6:0] hd_q;
    // Count rises and keep command and address of the frame
    always_ff @(posedge spi_clk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            cnt_q <= 5'h00;
            hd_q  <= 7'h00;
        end else begin
            cnt_q <= cnt_q + 5'h01;
            hd_q  <= (cnt_q < 5'h07) ? {hd_q[5:0], spi_sdi} : hd_q;
        end
    end
    // Byte that a read of the captured address must return; 0x0A is not modelled and gives zero
    wire [4:0]  ad   = hd_q[4:0];
    wire [7:0]  stat = {3'h0, ldo_good, buck_two_good, buck_one_good, 1'h0, vin_cmp_high};
    wire [7:0]  img  = (ad == 5'h00) ? {1'h0, buck_two_code} :
        (ad == 5'h08) ? {2'h0, buck_one_code} :
        (ad == 5'h0B) ? {vin_hyst_double, vin_trip_code, vin_monitor_on} :
        (ad == 5'h0C) ? {3'h0, event_mask} : (ad == 5'h0D) ? stat : 8'h00;
    wire [28:0] outs = {buck_two_code, buck_one_code, first_buck_fixed_pwm,
        second_buck_fixed_pwm, first_buck_on, vin_trip_code, vin_hyst_double,
        vin_monitor_on, event_mask};
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_code_rst; @(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_n) |-> buck_two_code == 7'h64 && buck_one_code == 6'h0E;
    endproperty
    a_code_rst: assert property (p_code_rst) else $error("buck code reset wrong");
    property p_ctl_rst; @(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_n) |-> {first_buck_fixed_pwm, second_buck_fixed_pwm, first_buck_on} == 3'h1;
    endproperty
    a_ctl_rst: assert property (p_ctl_rst) else $error("control reset wrong");
    property p_mon_rst; @(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_n) |-> {vin_hyst_double, vin_trip_code, vin_monitor_on} == 8'h33;
    endproperty
    a_mon_rst: assert property (p_mon_rst) else $error("monitor reset wrong");
    property p_mask_rst; @(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_n) |-> event_mask == 5'h01;
    endproperty
    a_mask_rst: assert property (p_mask_rst) else $error("mask reset wrong");
    property p_idle; @(posedge sys_clk) disable iff (!rst_n)
        spi_cs_n && $past(spi_cs_n) |-> !spi_sdo;
    endproperty
    a_idle: assert property (p_idle) else $error("output busy while deselected");
    property p_quiet; @(posedge sys_clk) disable iff (!rst_n)
        !$stable(outs) |-> spi_cs_n && $past(spi_cs_n, 2);
    endproperty
    a_quiet: assert property (p_quiet) else $error("control moved in a frame");
    property p_wr0; @(posedge spi_clk) disable iff (spi_cs_n)
        cnt_q >= 5'h07 && hd_q[6:5] == 2'h2 |-> !spi_sdo;
    endproperty
    a_wr0: assert property (p_wr0) else $error("output not low in write");
    property p_rd; @(posedge spi_clk) disable iff (spi_cs_n)
        cnt_q >= 5'h07 && hd_q[6:5] == 2'h3 && ad != 5'h0A |-> spi_sdo == img[5'h0E - cnt_q];
    endproperty
    a_rd: assert property (p_rd) else $error("read bit wrong");
    // Main scenarios reached
    c_rd: cover property (@(posedge spi_clk) cnt_q == 5'h0E && hd_q[6:5] == 2'h3);
    c_wr: cover property (@(posedge spi_clk) cnt_q == 5'h0E && hd_q[6:5] == 2'h2);
    c_upd: cover property (@(posedge sys_clk) disable iff (!rst_n) !$stable(outs));
endmodule

bind pcr_regs pcr_regs_chk u_chk (
    .sys_clk, .rst_n, .spi_clk, .spi_cs_n, .spi_sdi, .spi_sdo, .ldo_good, .buck_two_good,
    .buck_one_good, .vin_cmp_high, .buck_two_code, .buck_one_code, .first_buck_fixed_pwm,
    .second_buck_fixed_pwm, .first_buck_on, .vin_trip_code, .vin_hyst_double,
    .vin_monitor_on, .event_mask
);

`default_nettype wire

// file: pcr_host.sv
// Link master model that sends frames on the serial link.
// Assumes the bench calls xfer; the clock stays low between frames.
`timescale 1ns/1ps
`default_nettype none

module pcr_host (
    output var logic  spi_clk,
    output var logic  spi_cs_n,
    output var logic  spi_sdi,
    input  wire logic spi_sdo
);
    int half = 15;  // Half period in ns; raised for a slow master

    // Idle link: deselected, clock still
    initial begin
        spi_clk = 1'b0;
        spi_cs_n = 1'b0;  // A clean select rise clears the link's frame state
        spi_sdi = 1'b0;
        #1 spi_cs_n = 1'b1;
    end

    // One frame of n rises, MSB first, none for addresses 0x07 and 0x09; bits seen at rises 8 on are kept
    task automatic xfer(input logic [14:0] f, input int n, output logic [7:0] d);
        d = 8'h00;
        if (f[12:8] == 5'h07 || f[12:8] == 5'h09) return;
        #7.3 spi_cs_n <= 1'b0;
        #(half);  // Select setup before the first rise
        for (int i = 0; i < n; i++) begin
            spi_sdi <= f[14 - i];
            #(half) spi_clk <= 1'b1;
            if (i >= 7) d = {d[6:0], spi_sdo};
            #(half) spi_clk <= 1'b0;
        end
        spi_sdi <= ~spi_sdi;  // Released line shows no stale bit
        #(half) spi_cs_n <= 1'b1;
        #60;  // Gap between frames
    endtask
endmodule

`default_nettype wire

// file: pcr_regs_tb.sv
// Self-checking bench for the regulator configuration register bank.
// Assumes pcr_host as link master and the bound port checker.
`timescale 1ns/1ps
`default_nettype none

module pcr_regs_tb;
    logic       sys_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [3:0] g = 4'h0;  // Good pins: ldo, buck two, buck one, comparator
    wire        spi_clk, spi_cs_n, spi_sdi, spi_sdo;
    logic [6:0] buck_two_code;
    logic [5:0] buck_one_code, vin_trip_code;
    logic       first_buck_fixed_pwm, second_buck_fixed_pwm, first_buck_on;
    logic       vin_hyst_double, vin_monitor_on;
    logic [4:0] event_mask;
    int         fails = 0;
    int         checked = 0;
    logic [4:0] ra [5] = '{5'h00, 5'h08, 5'h0A, 5'h0B, 5'h0C};
    logic [7:0] rv [5] = '{8'h64, 8'h0E, 8'h01, 8'h33, 8'h01};
    logic [3:0] sp [3] = '{4'hF, 4'h5, 4'hA};
    logic [7:0] sts [3] = '{8'h1D, 8'h09, 8'h14};
    wire  [7:0] ctl = {5'h0, first_buck_fixed_pwm, second_buck_fixed_pwm, first_buck_on};
    wire  [7:0] mon = {vin_hyst_double, vin_trip_code, vin_monitor_on};

    pcr_regs DUT (
        .sys_clk, .rst_n, .spi_clk, .spi_cs_n, .spi_sdi, .spi_sdo,
        .ldo_good(g[3]), .buck_two_good(g[2]), .buck_one_good(g[1]), .vin_cmp_high(g[0]),
        .buck_two_code, .buck_one_code, .first_buck_fixed_pwm, .second_buck_fixed_pwm,
        .first_buck_on, .vin_trip_code, .vin_hyst_double, .vin_monitor_on, .event_mask
    );
    pcr_host u_host (.spi_clk, .spi_cs_n, .spi_sdi, .spi_sdo);

    // 200 MHz system clock
    always #2.5 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_host.xfer({2'h3, a, 8'h00}, 15, d);
        chk(d, e);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        logic [7:0] d;
        u_host.xfer({2'h2, a, v}, 15, d);
        chk(d, 8'h00);
    endtask
    task automatic wrd(input logic [4:0] a, input logic [7:0] v, input logic [7:0] e);
        wr(a, v);
        rd(a, e);
    endtask
    task automatic do_reset;
        @(posedge sys_clk) rst_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic report_and_stop;
        if (fails == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_defaults;
        chk({1'h0, buck_two_code}, 8'h64);
        chk({2'h0, buck_one_code}, 8'h0E);
        chk(ctl, 8'h01);
        chk(mon, 8'h33);
        chk({3'h0, event_mask}, 8'h01);
        for (int i = 0; i < 5; i++) rd(ra[i], rv[i]);
    endtask
    task automatic t_write;
        wrd(5'h00, 8'hFF, 8'h7F);
        chk({1'h0, buck_two_code}, 8'h7F);
        wrd(5'h08, 8'hC1, 8'h01);
        chk({2'h0, buck_one_code}, 8'h01);
        wrd(5'h0A, 8'h0C, 8'h0C);
        chk(ctl, 8'h06);
        wrd(5'h0A, 8'h09, 8'h09);
        chk(ctl, 8'h05);
        wrd(5'h0B, 8'hD4, 8'hD4);
        chk(mon, 8'hD4);
        wrd(5'h0B, 8'h7F, 8'h7F);
        chk(mon, 8'h7F);
        wrd(5'h0C, 8'h1D, 8'h1D);
        chk({3'h0, event_mask}, 8'h1D);
    endtask
    // Bad commands, a frame one rise short and an aliasing address
    task automatic t_refuse;
        logic [7:0] d;
        for (int c = 0; c < 2; c++) u_host.xfer({2'(c), 5'h00, 8'h00}, 15, d);
        u_host.xfer({2'h2, 5'h00, 8'h00}, 14, d);
        wr(5'h10, 8'h00);
        wr(5'h0D, 8'h00);
        chk({1'h0, buck_two_code}, 8'h7F);
        rd(5'h10, 8'h00);
    endtask
    task automatic t_status;
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk) g <= sp[i];
            repeat (4) @(posedge sys_clk);
            rd(5'h0D, sts[i]);
        end
    endtask
    task automatic t_slow;
        u_host.half = 40;
        wrd(5'h08, 8'h2A, 8'h2A);
        u_host.half = 15;
        chk({2'h0, buck_one_code}, 8'h2A);
    endtask

    // Main sequence, ending with a reset in mid-run
    initial begin
        do_reset;
        t_defaults;
        t_write;
        t_refuse;
        t_status;
        t_slow;
        do_reset;
        t_defaults;
        report_and_stop;
    end

    // Watchdog: the run needs some 21 us
    initial begin
        #100000;
        fails++;
        report_and_stop;
    end
endmodule

`default_nettype wire
